// *** sbrp_pkg.sv ***
// Purpose: shared constants and types for the system bus request phase ends
// Assumes: all bus pins except bus_clk active low on the wire
// Notes: addresses are 8-byte granular, bits 35..3 carried
package sbrp_pkg;
  localparam int SBRP_ADDR_W = 33;
  localparam int SBRP_ADDR_LSB = 3;
  localparam int SBRP_REQ_W = 5;
  localparam int SBRP_MON_W = 4;
  localparam int SBRP_LO_W = 14;
  localparam int SBRP_HI_W = 19;
  localparam int SBRP_MASK_BIT = 20 - SBRP_ADDR_LSB;
  localparam logic [32:0] SBRP_ADDR_RST = 33'h0_0000_0000;
  localparam logic [32:0] SBRP_STRAP_RST = 33'h1_FFFF_FFFF;
  localparam logic [4:0] SBRP_REQ_RST = 5'h00;
  localparam logic [3:0] SBRP_MON_RST = 4'h0;
  localparam logic [32:0] SBRP_ADDR_ONES = 33'h1_FFFF_FFFF;
  localparam logic [4:0] SBRP_REQ_ONES = 5'h1F;
  localparam int SBRP_CLK_DIV = 2;
  localparam logic [1:0] SBRP_DIV_MAX = 2'h1;
  localparam logic [3:0] SBRP_RST_REL = 4'h4;
  localparam logic [3:0] SBRP_RST_END = 4'hF;
  typedef enum logic [3:0] {
    SBRP_IDLE = 4'h1,
    SBRP_SUB1 = 4'h2,
    SBRP_SUB2 = 4'h4,
    SBRP_WAIT = 4'h8
  } sbrp_state_type;
endpackage

// *** sbrp_bus_if.sv ***
// Purpose: wires between processor end and hub end of the request phase
// Assumes: every pin except bus_clk active low, 1 means released; drive enables active high
// Notes: two-way pins resolve as wired AND of enabled drivers
`timescale 1ns/1ps
interface sbrp_bus_if;
  import sbrp_pkg::*;
  logic bus_clk;
  logic [32:0] addr_o_cpu;
  logic addr_oe_cpu;
  logic [32:0] addr_o_hub;
  logic addr_oe_hub;
  logic [32:0] addr_n;
  logic [4:0] req_n;
  logic [1:0] addr_src_sync_strobe_n;
  logic addr_valid_strobe_n;
  logic bnr_o_cpu;
  logic bnr_o_hub;
  logic block_next_req_n;
  logic addr_bit20_mask_n;
  logic target_ready_n;
  logic [3:0] bpm_o;
  logic [3:0] bpm_oe;
  logic [3:0] bpm_ext_n;
  logic [3:0] breakpoint_perf_mon_n;
  logic sys_reset_n;
  // wired resolution of shared pins
  assign addr_n = (addr_oe_cpu ? addr_o_cpu : SBRP_ADDR_ONES) & (addr_oe_hub ? addr_o_hub : SBRP_ADDR_ONES);
  assign block_next_req_n = bnr_o_cpu & bnr_o_hub;
  assign breakpoint_perf_mon_n = (bpm_o | ~bpm_oe) & bpm_ext_n;
  modport cpu (
    input bus_clk, addr_n, block_next_req_n, addr_bit20_mask_n, target_ready_n,
    input breakpoint_perf_mon_n, sys_reset_n,
    output addr_o_cpu, addr_oe_cpu, req_n, addr_src_sync_strobe_n, addr_valid_strobe_n,
    output bnr_o_cpu, bpm_o, bpm_oe
  );
  modport hub (
    input addr_n, req_n, addr_src_sync_strobe_n, addr_valid_strobe_n, block_next_req_n,
    output bus_clk, addr_o_hub, addr_oe_hub, bnr_o_hub, addr_bit20_mask_n, target_ready_n,
    output sys_reset_n
  );
endinterface

// *** sbrp_cpu.sv ***
// Purpose: processor end, issues two sub-phase requests on the bus clock
// Assumes: user request pulses and stall level are on clk
// Notes: events cross by toggle, words by held registers
// How it works
// - sub-phase one drives the 33 address bits
// - sub-phase two drives transaction type
// - receiver captures address with address strobes
// - address straps sampled before reset release
// - mask input clears address bit 20
// - platform masks bit 20 only in real mode
// - mask valid at target ready of I/O write; processor end ignores target ready, samples mask each bus clock
// - address valid strobe marks address and request
// - agents start checks on address valid strobe
// - strobes latch both edges, split lo/hi bits
// - drive on bus clock rising; strobes, and the hub latches they clock, move on bus clock falling
// - full agent asserts block next request
// - no new transaction while bus stalled
// - four monitor pins report breakpoint and counters
`timescale 1ns/1ps
module sbrp_cpu
  import sbrp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  sbrp_bus_if.cpu bus,
  input wire logic req_valid,
  input wire logic [32:0] req_addr,
  input wire logic [4:0] req_type_a,
  input wire logic [32:0] req_type_b,
  output logic req_ready,
  output logic req_done,
  input wire logic cpu_busy,
  input wire logic [3:0] mon_status,
  output logic [3:0] mon_in,
  output logic [32:0] strap_value,
  output logic strap_valid
);
  import sbrp_pkg::*;
  sbrp_state_type st_q, st_d;
  logic [32:0] addr_q, addr_d, type_q, type_d;
  logic [4:0] req_q, req_d;
  logic go_tgl_q, go_tgl_d, done_tgl_q, done_tgl_d;
  logic [32:0] strap_q, strap_d;
  logic strap_vld_q, strap_vld_d;
  logic go_s1_q, go_s2_q, go_seen_q, done_s1_q, done_s2_q, done_seen_q;
  logic bnr_s_q, mask_s1_q, mask_s2_q, busy_s1_q, busy_s2_q;
  logic bnr_s2_q, rstn_s1_q, rstn_s2_q, strb_n_q;
  logic [3:0] mon_s1_q, mon_s2_q, mon_out_q, mon_l1_q, mon_l2_q;
  logic busy_q, busy_d;

  // user side request capture, crossing by toggle
  always_comb
  begin
    busy_d = busy_q;
    go_tgl_d = go_tgl_q;
    addr_d = addr_q;
    type_d = type_q;
    req_d = req_q;
    if (req_valid && !busy_q)
    begin
      busy_d = 1'b1;
      go_tgl_d = ~go_tgl_q;
      addr_d = req_addr;
      type_d = req_type_b;
      req_d = req_type_a;
    end
    if (done_s2_q != done_seen_q)
      busy_d = 1'b0;
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      busy_q <= 1'b0;
      go_tgl_q <= 1'b0;
      addr_q <= SBRP_ADDR_RST;
      type_q <= SBRP_ADDR_RST;
      req_q <= SBRP_REQ_RST;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_seen_q <= 1'b0;
      mon_l1_q <= SBRP_MON_RST;
      mon_l2_q <= SBRP_MON_RST;
    end
    else
    begin
      busy_q <= busy_d;
      go_tgl_q <= go_tgl_d;
      addr_q <= addr_d;
      type_q <= type_d;
      req_q <= req_d;
      done_s1_q <= done_tgl_q;
      done_s2_q <= done_s1_q;
      done_seen_q <= done_s2_q;
      mon_l1_q <= bus.breakpoint_perf_mon_n;
      mon_l2_q <= mon_l1_q;
    end
  end
  assign req_ready = !busy_q;
  assign req_done = (done_s2_q != done_seen_q);
  assign mon_in = ~mon_l2_q; // two-way pins read back
  assign strap_value = strap_q;
  assign strap_valid = strap_vld_q;

  // link side request phase machine
  always_comb
  begin
    st_d = st_q;
    done_tgl_d = done_tgl_q;
    strap_d = strap_q;
    strap_vld_d = strap_vld_q;
    if (!strap_vld_q && !rstn_s2_q)
      strap_d = ~bus.addr_n;
    if (rstn_s2_q)
      strap_vld_d = 1'b1;
    case (st_q)
      SBRP_IDLE:
        if (strap_vld_q && go_s2_q != go_seen_q && bnr_s2_q)
          st_d = SBRP_SUB1;
      SBRP_SUB1: st_d = SBRP_SUB2;
      SBRP_SUB2: st_d = SBRP_WAIT;
      SBRP_WAIT:
      begin
        done_tgl_d = ~done_tgl_q;
        st_d = SBRP_IDLE;
      end
      default: st_d = SBRP_IDLE;
    endcase
  end
  always_ff @(posedge bus.bus_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q <= SBRP_IDLE;
      done_tgl_q <= 1'b0;
      strap_q <= SBRP_ADDR_RST;
      strap_vld_q <= 1'b0;
      go_s1_q <= 1'b0;
      go_s2_q <= 1'b0;
      go_seen_q <= 1'b0;
      bnr_s_q <= 1'b1;
      bnr_s2_q <= 1'b1;
      rstn_s1_q <= 1'b0;
      rstn_s2_q <= 1'b0;
      mask_s1_q <= 1'b1;
      mask_s2_q <= 1'b1;
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      mon_s1_q <= SBRP_MON_RST;
      mon_s2_q <= SBRP_MON_RST;
      mon_out_q <= SBRP_MON_RST;
    end
    else
    begin
      st_q <= st_d;
      done_tgl_q <= done_tgl_d;
      strap_q <= strap_d;
      strap_vld_q <= strap_vld_d;
      go_s1_q <= go_tgl_q;
      go_s2_q <= go_s1_q;
      if (st_q == SBRP_IDLE && st_d == SBRP_SUB1)
        go_seen_q <= go_s2_q;
      bnr_s_q <= bus.block_next_req_n; // stall pin from the hub clock, two flops
      bnr_s2_q <= bnr_s_q;
      rstn_s1_q <= bus.sys_reset_n; // bus reset from the hub clock, two flops
      rstn_s2_q <= rstn_s1_q;
      mask_s1_q <= bus.addr_bit20_mask_n; // asynchronous pin
      mask_s2_q <= mask_s1_q;
      busy_s1_q <= cpu_busy;
      busy_s2_q <= busy_s1_q;
      mon_s1_q <= mon_status;
      mon_s2_q <= mon_s1_q;
      mon_out_q <= mon_s2_q;
    end
  end

  // pin drive, active low on the wire
  always_comb
  begin
    bus.addr_o_cpu = SBRP_ADDR_ONES;
    bus.addr_oe_cpu = 1'b0;
    bus.req_n = SBRP_REQ_ONES;
    bus.addr_valid_strobe_n = 1'b1;
    if (st_q == SBRP_SUB1)
    begin
      bus.addr_oe_cpu = 1'b1;
      bus.addr_o_cpu = ~addr_q;
      bus.addr_o_cpu[SBRP_MASK_BIT] = ~(addr_q[SBRP_MASK_BIT] & mask_s2_q);
      bus.req_n = ~req_q;
      bus.addr_valid_strobe_n = 1'b0;
    end
    else if (st_q == SBRP_SUB2)
    begin
      bus.addr_oe_cpu = 1'b1;
      bus.addr_o_cpu = ~type_q;
      bus.req_n = ~req_q;
    end
  end
  // strobes move mid sub-phase: fall inside address, rise inside type
  always_ff @(negedge bus.bus_clk or posedge sys_rst)
  begin
    if (sys_rst)
      strb_n_q <= 1'b1;
    else
      strb_n_q <= (st_q != SBRP_SUB1);
  end
  assign bus.addr_src_sync_strobe_n = {2{strb_n_q}};
  assign bus.bnr_o_cpu = !busy_s2_q ? 1'b1 : 1'b0;
  assign bus.bpm_o = ~mon_out_q;
  assign bus.bpm_oe = 4'hF;
endmodule

// *** sbrp_hub.sv ***
// Purpose: hub end, makes bus clock, captures requests by strobe edges
// Assumes: processor end issues on bus clock rising edges
// Notes: captured request passed to clk domain by toggle
`timescale 1ns/1ps
module sbrp_hub
  import sbrp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  sbrp_bus_if.hub bus,
  input wire logic hub_full,
  input wire logic a20_mask,
  input wire logic tgt_ready,
  input wire logic [32:0] strap_drive,
  output logic [32:0] got_addr,
  output logic [4:0] got_req,
  output logic [32:0] got_type,
  output logic got_valid
);
  import sbrp_pkg::*;
  logic [1:0] div_q, div_d;
  logic bclk_q, bclk_d;
  logic [3:0] rst_cnt_q, rst_cnt_d;
  logic [SBRP_LO_W-1:0] lo_q;
  logic [SBRP_HI_W-1:0] hi_q;
  logic [4:0] req_q;
  logic [SBRP_LO_W-1:0] tlo_q;
  logic [SBRP_HI_W-1:0] thi_q;
  logic lat_q, tgl_q, s1_q, s2_q, s3_q, vld_q;
  logic [32:0] oa_q;
  logic [4:0] or_q;
  logic [32:0] ot_q;

  // bus clock divider and reset hold for strap sampling
  always_comb
  begin
    div_d = (div_q == SBRP_DIV_MAX) ? 2'h0 : div_q + 2'h1;
    bclk_d = (div_q == SBRP_DIV_MAX) ? ~bclk_q : bclk_q;
    rst_cnt_d = (rst_cnt_q == SBRP_RST_END) ? rst_cnt_q : rst_cnt_q + 4'h1;
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_q <= 2'h0;
      bclk_q <= 1'b0;
      rst_cnt_q <= 4'h0;
    end
    else
    begin
      div_q <= div_d;
      bclk_q <= bclk_d;
      rst_cnt_q <= rst_cnt_d;
    end
  end
  assign bus.bus_clk = bclk_q;
  // bus reset released early so straps outlast the processor's reset sync
  assign bus.sys_reset_n = (rst_cnt_q >= SBRP_RST_REL);
  assign bus.addr_oe_hub = (rst_cnt_q != SBRP_RST_END); // straps during and just after reset
  assign bus.addr_o_hub = ~strap_drive;
  assign bus.bnr_o_hub = ~hub_full;
  assign bus.addr_bit20_mask_n = ~a20_mask;
  assign bus.target_ready_n = ~tgt_ready;

  // strobe-edge capture of both sub-phases
  always_ff @(negedge bus.addr_src_sync_strobe_n[0] or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lo_q <= 14'h0000;
      req_q <= SBRP_REQ_RST;
    end
    else
    begin
      lo_q <= ~bus.addr_n[SBRP_LO_W-1:0];
      req_q <= ~bus.req_n;
    end
  end
  always_ff @(negedge bus.addr_src_sync_strobe_n[1] or posedge sys_rst)
  begin
    if (sys_rst)
      hi_q <= 19'h00000;
    else
      hi_q <= ~bus.addr_n[SBRP_ADDR_W-1:SBRP_LO_W];
  end
  // rising strobe edges take the type word of sub-phase two
  always_ff @(posedge bus.addr_src_sync_strobe_n[0] or posedge sys_rst)
  begin
    if (sys_rst)
      tlo_q <= 14'h0000;
    else
      tlo_q <= ~bus.addr_n[SBRP_LO_W-1:0];
  end
  always_ff @(posedge bus.addr_src_sync_strobe_n[1] or posedge sys_rst)
  begin
    if (sys_rst)
      thi_q <= 19'h00000;
    else
      thi_q <= ~bus.addr_n[SBRP_ADDR_W-1:SBRP_LO_W];
  end
  // address valid strobe opens decode, type taken one bus clock later
  always_ff @(posedge bclk_q or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      lat_q <= 1'b0;
      tgl_q <= 1'b0;
    end
    else
    begin
      lat_q <= !bus.addr_valid_strobe_n;
      if (lat_q)
        tgl_q <= ~tgl_q; // type already latched by rising strobes
    end
  end
  // toggle crossing into clk
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      vld_q <= 1'b0;
      oa_q <= SBRP_ADDR_RST;
      or_q <= SBRP_REQ_RST;
      ot_q <= SBRP_ADDR_RST;
    end
    else
    begin
      s1_q <= tgl_q;
      s2_q <= s1_q;
      s3_q <= s2_q;
      vld_q <= (s2_q != s3_q); // one clk pulse with the new words
      if (s2_q != s3_q)
      begin
        oa_q <= {hi_q, lo_q};
        or_q <= req_q;
        ot_q <= {thi_q, tlo_q};
      end
    end
  end
  assign got_addr = oa_q;
  assign got_req = or_q;
  assign got_type = ot_q;
  assign got_valid = vld_q;
endmodule

// *** sbrp_bus_monitor.sv ***
// Purpose: wire checks of the request phase
// Assumes: bus clock from hub end, pins active low
// Notes: idle while bus reset is low
`timescale 1ns/1ps
module sbrp_bus_monitor
  import sbrp_pkg::*;
(
  input wire logic bus_clk,
  input wire logic sys_reset_n,
  input wire logic [32:0] addr_n,
  input wire logic addr_oe_cpu,
  input wire logic addr_oe_hub,
  input wire logic [1:0] addr_src_sync_strobe_n,
  input wire logic addr_valid_strobe_n,
  input wire logic block_next_req_n,
  input wire logic addr_bit20_mask_n
);
  import sbrp_pkg::*;
  // all checks on bus clock
  default clocking cb @(posedge bus_clk); endclocking
  default disable iff (!sys_reset_n);
  addr_driven_a: assert property (!addr_valid_strobe_n |-> addr_oe_cpu)
    else $error("address not driven with strobe");
  type_phase_a: assert property (!addr_valid_strobe_n |=> addr_oe_cpu && addr_valid_strobe_n)
    else $error("no type sub-phase");
  strobe_pair_a: assert property (!addr_valid_strobe_n |-> addr_src_sync_strobe_n == 2'h0)
    else $error("strobes missing in sub-phase one");
  strobe_quiet_a: assert property (addr_valid_strobe_n [*2] |-> addr_src_sync_strobe_n == 2'h3)
    else $error("strobes outside request");
  valid_pulse_a: assert property ($fell(addr_valid_strobe_n) |=> $rose(addr_valid_strobe_n))
    else $error("valid strobe not one cycle");
  stall_hold_a: assert property (!block_next_req_n [*4] |-> addr_valid_strobe_n)
    else $error("request during stall");
  mask_bit_a: assert property (!addr_bit20_mask_n [*4] ##0 !addr_valid_strobe_n |-> addr_n[SBRP_MASK_BIT])
    else $error("bit 20 not masked");
  strap_owner_a: assert property (addr_oe_hub |-> !addr_oe_cpu)
    else $error("address lines driven by both ends");
endmodule

// *** testbench.sv ***
// Purpose: both ends of the request phase back to back
// Assumes: bus clock divided from clk in the hub end
// Notes: captured words checked on the got_valid pulse
`timescale 1ns/1ps
module testbench;
  import sbrp_pkg::*;
  localparam logic [32:0] STRAP = 33'h0_2468_ACE1;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0, cpu_busy = 1'b0, hub_full = 1'b0, a20_mask = 1'b0, tgt_ready = 1'b0;
  logic [32:0] req_addr = 33'h0, req_type_b = 33'h0;
  logic [4:0] req_type_a = 5'h00;
  logic [3:0] mon_status = 4'h0;
  logic req_ready, req_done, strap_valid, got_valid;
  logic [3:0] mon_in;
  logic [32:0] strap_value, got_addr, got_type;
  logic [4:0] got_req;
  int fail_count = 0;
  int n_checks = 0;
  sbrp_bus_if u_sbrp_bus_if();
  sbrp_cpu u_sbrp_cpu(.clk(clk), .sys_rst(sys_rst), .bus(u_sbrp_bus_if), .req_valid(req_valid),
    .req_addr(req_addr), .req_type_a(req_type_a), .req_type_b(req_type_b), .req_ready(req_ready),
    .req_done(req_done), .cpu_busy(cpu_busy), .mon_status(mon_status), .mon_in(mon_in),
    .strap_value(strap_value), .strap_valid(strap_valid));
  sbrp_hub u_sbrp_hub(.clk(clk), .sys_rst(sys_rst), .bus(u_sbrp_bus_if), .hub_full(hub_full),
    .a20_mask(a20_mask), .tgt_ready(tgt_ready), .strap_drive(STRAP), .got_addr(got_addr),
    .got_req(got_req), .got_type(got_type), .got_valid(got_valid));
  sbrp_bus_monitor u_sbrp_bus_monitor(.bus_clk(u_sbrp_bus_if.bus_clk), .sys_reset_n(u_sbrp_bus_if.sys_reset_n),
    .addr_n(u_sbrp_bus_if.addr_n), .addr_oe_cpu(u_sbrp_bus_if.addr_oe_cpu),
    .addr_oe_hub(u_sbrp_bus_if.addr_oe_hub), .addr_src_sync_strobe_n(u_sbrp_bus_if.addr_src_sync_strobe_n),
    .addr_valid_strobe_n(u_sbrp_bus_if.addr_valid_strobe_n),
    .block_next_req_n(u_sbrp_bus_if.block_next_req_n), .addr_bit20_mask_n(u_sbrp_bus_if.addr_bit20_mask_n));
  // debug tool leaves monitor pins released
  initial u_sbrp_bus_if.bpm_ext_n = 4'hF;
  // user clock
  initial forever #10 clk = ~clk;
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic timeout(input string what);
    fail_count++;
    $display("mismatch %s expected done seen timeout", what);
    summarize();
  endtask
  // one request, held until taken; stall released after quiet cycles
  task automatic xfer(input logic [32:0] a, input logic [4:0] t, input logic [32:0] b, input logic [32:0] ea,
    input int quiet);
    int k;
    logic seen, vseen;
    seen = 1'b0;
    vseen = 1'b0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_type_a <= t;
    req_type_b <= b;
    for (k = 0; k < 800 && !(seen && vseen); k++)
    begin
      @(negedge clk);
      if (req_done === 1'b1)
        seen = 1'b1;
      if (got_valid === 1'b1)
      begin
        vseen = 1'b1;
        chk("got_addr", ea, got_addr);
        chk("got_type", b, got_type);
        chk("got_req", {28'h0, t}, {28'h0, got_req});
      end
      if ((seen || vseen) && k < quiet)
        chk("done while stalled", 33'h0, 33'h1);
      if (req_valid && req_ready === 1'b1)
      begin
        @(posedge clk);
        req_valid <= 1'b0;
      end
      if (k == quiet)
      begin
        @(posedge clk);
        hub_full <= 1'b0;
      end
    end
    if (!seen || !vseen)
      timeout("req_done and got_valid");
  endtask
  task automatic test_strap;
    int k;
    for (k = 0; k < 600 && strap_valid !== 1'b1; k++)
      @(negedge clk);
    if (strap_valid !== 1'b1)
      timeout("strap_valid");
    chk("strap_value", STRAP, strap_value);
    $display("test strap done");
  endtask
  task automatic test_burst;
    logic [32:0] tab [3] = '{33'h1_FFFF_FFFF, 33'h0_0000_3FFF, 33'h1_FFFF_C000};
    logic [4:0] tt [3] = '{5'h1F, 5'h0A, 5'h15};
    for (int i = 0; i < 3; i++)
      xfer(tab[i], tt[i], ~tab[i], tab[i], 0);
    $display("test burst done");
  endtask
  task automatic test_mask;
    @(posedge clk);
    a20_mask <= 1'b1;
    tgt_ready <= 1'b1;
    repeat (40) @(posedge clk);
    xfer(33'h1_FFFF_FFFF, 5'h01, 33'h0_1234_5678, 33'h1_FFFF_FFFF & ~(33'h1 << SBRP_MASK_BIT), 0);
    @(posedge clk);
    a20_mask <= 1'b0;
    tgt_ready <= 1'b0;
    $display("test mask done");
  endtask
  task automatic test_stall;
    @(posedge clk);
    hub_full <= 1'b1;
    repeat (40) @(posedge clk);
    chk("stall wire", 33'h0, {32'h0, u_sbrp_bus_if.block_next_req_n});
    xfer(33'h0_0F0F_0F0F, 5'h03, 33'h1_0000_0001, 33'h0_0F0F_0F0F, 60);
    $display("test stall done");
  endtask
  task automatic test_busy;
    @(posedge clk);
    cpu_busy <= 1'b1;
    repeat (40) @(posedge clk);
    chk("busy stall", 33'h0, {32'h0, u_sbrp_bus_if.block_next_req_n});
    cpu_busy <= 1'b0;
    repeat (40) @(posedge clk);
    chk("busy release", 33'h1, {32'h0, u_sbrp_bus_if.block_next_req_n});
    $display("test busy done");
  endtask
  task automatic test_monitor;
    @(posedge clk);
    mon_status <= 4'h9;
    repeat (20) @(posedge clk);
    chk("monitor wire", 33'h6, {29'h0, u_sbrp_bus_if.breakpoint_perf_mon_n});
    chk("mon_in", 33'h9, {29'h0, mon_in});
    $display("test monitor done");
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    test_strap();
    test_burst();
    test_mask();
    test_stall();
    test_busy();
    test_monitor();
    summarize();
  end
endmodule
